//--- selfprog_defs.svh
// Offsets, bit positions, reset values and timing counts of the self-program controller.
`ifndef SELFPROG_DEFS_SVH
`define SELFPROG_DEFS_SVH

// ==========================================================================
// Register placement
// ==========================================================================
`define CTRL_IDX     8'h37
`define CTRL_ADDR    {`CTRL_IDX, 2'h0}

// ==========================================================================
// Control and status bit positions
// ==========================================================================
`define BIT_IE       7
`define BIT_RWWB     6
`define BIT_RES      5
`define BIT_RWW_READ_REENABLE   4
`define BIT_LOCK_BITS_SET   3
`define BIT_PAGE_WRITE_CMD    2
`define BIT_PAGE_ERASE_CMD    1
`define BIT_SPMEN    0

// ==========================================================================
// Lock byte positions and reset values
// ==========================================================================
`define LK_MEM_LO    0
`define LK_MEM_HI    1
`define LK_APP_LO    2
`define LK_APP_HI    3
`define LK_BOOT_LO   4
`define LK_BOOT_HI   5
`define LOCK_RST     6'h3f
`define LOCK_PAD     2'h3
`define CTRL_RST     8'h00

// ==========================================================================
// Timing counts in clock cycles
// ==========================================================================
`define WIN_CYC      3'h4
`define LPM_WIN_LAST 3'h2

`endif

//--- selfprog_pkg.sv
// Types shared by the self-program controller.
package selfprog_pkg;

    // Gray coded along idle, armed, busy.
    typedef enum logic [1:0] {
        OP_IDLE  = 2'h0,
        OP_ARMED = 2'h1,
        OP_BUSY  = 2'h3
    } op_t;

    // Accepted patterns of the five low control bits.
    typedef enum logic [4:0] {
        CMD_FILL  = 5'h01,
        CMD_ERASE = 5'h03,
        CMD_WRITE = 5'h05,
        CMD_LOCK  = 5'h09,
        CMD_RWWEN = 5'h11
    } cmd_t;

endpackage : selfprog_pkg

//--- self_program_flash_control.sv
// Self-programming controller for on-chip program flash, with APB register access.
//
// Notes on behaviour
// - Ready interrupt requested while enabled, global flag set and store enable clear.
// - Erase or write into concurrent section sets busy and blocks that section.
// - Busy cleared by re-enable store after completion, or by any buffer fill.
// - Re-enable arms a store for four cycles; refused while erase or write runs.
// - Writing re-enable while buffer holds data discards the loaded data.
// - Lock set store programs lock bits from the low operand only.
// - Load within three cycles of lock arming returns lock or fuse byte by pointer bit zero.
// - Page write store writes buffer to page from upper pointer bits.
// - Page erase store erases page from upper pointer bits.
// - Processor halted for whole erase or write into the non-concurrent section.
// - Store enable alone arms a buffer fill of both operands at pointer word.
// - Store enable clears after store or unused window; held through erase or write.
// - Only five low-bit patterns are accepted; other writes leave them unchanged.
// - Six lock bits, zero programmed; only chip erase returns them to one.
// - Without boot section, stores need the self-program fuse programmed.
// - Memory lock pair gates external programming, verification, fuse and boot locks.
// - Application lock pair blocks stores, boot reads and boot vectors.
// - Boot lock pair blocks stores, application reads and application vectors.
`timescale 1ns/1ps
`include "selfprog_defs.svh"

module self_program_flash_control
    import selfprog_pkg::*;
#(
    parameter int ADDR_W    = 12,
    parameter int PW        = 5,
    parameter int PGW       = 7,
    parameter int RWW_PAGES = 96,
    parameter int BOOT_PAGE = 96,
    parameter bit HAS_BOOT  = 1'h1
) (
    // Clock and reset.
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave.
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Processor core.
    input  wire logic              spm_req,
    input  wire logic              lpm_req,
    input  wire logic [15:0]       flash_pointer,
    input  wire logic [7:0]        operand_low_reg,
    input  wire logic [7:0]        operand_high_reg,
    input  wire logic              global_irq_en,
    input  wire logic              exec_in_boot,
    input  wire logic              vectors_in_boot,
    output logic                   cpu_halt,
    output logic                   ready_irq,
    output logic                   irq_vectors_off,
    output logic                   lpm_ack,
    output logic      [7:0]        lpm_data,
    output logic                   lpm_deny,
    // Fuses and chip erase.
    input  wire logic              selfprog_fuse_n,
    input  wire logic [7:0]        fuse_low_in,
    input  wire logic              chip_erase,
    // Flash array and page buffer.
    input  wire logic              flash_op_done,
    output logic                   buf_load,
    output logic      [PW-1:0]     buf_word,
    output logic      [15:0]       buf_data,
    output logic                   buf_discard,
    output logic                   page_erase_go,
    output logic                   page_write_go,
    output logic      [PGW-1:0]    page_sel,
    output logic                   rww_blocked,
    // Lock protection state.
    output logic                   ext_prog_block,
    output logic                   verify_block,
    output logic                   fuse_lock,
    output logic                   boot_lock_lock
);

    // ======================================================================
    // State
    // ======================================================================
    localparam logic [PGW-1:0] RWW_PG  = PGW'(RWW_PAGES);
    localparam logic [PGW-1:0] BOOT_PG = PGW'(BOOT_PAGE);

    typedef struct packed {
        op_t            op;
        logic [2:0]     win;
        logic [7:0]     ctrl;
        logic           buf_full;
        logic           pg_wr;
        logic [5:0]     locks;
        logic [7:0]     rdata;
        logic           ready;
        logic           slverr;
        logic           buf_load;
        logic [PW-1:0]  buf_word;
        logic [15:0]    buf_data;
        logic           buf_discard;
        logic           erase_go;
        logic           write_go;
        logic [PGW-1:0] page_sel;
        logic           halt;
        logic           lpm_ack;
        logic [7:0]     lpm_data;
        logic           lpm_deny;
        logic           irq;
        logic           ext_block;
        logic           verify_block;
        logic           fuse_lock;
        logic           bootlk_lock;
        logic           vec_off;
    } state_t;

    state_t r_reg;
    state_t r_next;

    // Pointer decode; bit zero never selects a word.
    logic [PGW-1:0] ptr_page;
    logic           in_boot;
    logic           in_rww;
    assign ptr_page = flash_pointer[PW+PGW:PW+1];
    assign in_boot  = HAS_BOOT && (ptr_page >= BOOT_PG);
    assign in_rww   = ptr_page < RWW_PG;

    // APB phase decode.
    logic setup;
    logic hit;
    logic wr;
    assign setup = psel && !penable;
    assign hit   = paddr == ADDR_W'(`CTRL_ADDR);
    assign wr    = psel && penable && r_reg.ready && pwrite && hit && pstrb[0];

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        logic       spm_go;
        logic       wr_ok;
        logic       prot;
        logic       special;
        logic [4:0] wcmd;
        r_next             = r_reg;
        spm_go             = 1'h0;
        wr_ok              = 1'h0;
        prot               = 1'h0;
        special            = 1'h0;
        wcmd               = pwdata[4:0];
        r_next.buf_load    = 1'h0;
        r_next.buf_discard = 1'h0;
        r_next.erase_go    = 1'h0;
        r_next.write_go    = 1'h0;
        r_next.lpm_ack     = 1'h0;
        r_next.lpm_deny    = 1'h0;

        // Bus answer: one wait-free access after a registered setup.
        r_next.ready  = setup && !r_reg.ready;
        r_next.slverr = setup && !hit;
        r_next.rdata  = (setup && hit) ?
                        {r_reg.ctrl[7:6], 1'h0, r_reg.ctrl[4:0]} : 8'h00;

        if (r_reg.win != 3'h0) begin
            r_next.win = 3'(r_reg.win - 3'h1);
        end

        // Small variant gates every store on the fuse.
        spm_go = spm_req && (r_reg.op == OP_ARMED) && (r_reg.win != 3'h0)
                 && (HAS_BOOT || !selfprog_fuse_n);

        // Section locks forbid erase and write in that section.
        prot = HAS_BOOT && (in_boot ? !r_reg.locks[`LK_BOOT_LO]
                                    : !r_reg.locks[`LK_APP_LO]);

        if (spm_go) begin
            case (r_reg.ctrl[4:0])
                // Re-enable store clears the busy flag.
                CMD_RWWEN: begin
                    r_next.ctrl[`BIT_RWWB] = 1'h0;
                    r_next.ctrl[4:0]       = 5'h00;
                    r_next.op              = OP_IDLE;
                end
                // Lock set takes only the low operand.
                CMD_LOCK: begin
                    r_next.locks     = r_reg.locks & operand_low_reg[5:0];
                    r_next.ctrl[4:0] = 5'h00;
                    r_next.op        = OP_IDLE;
                end
                // Erase or write the page from upper pointer bits.
                CMD_ERASE, CMD_WRITE: begin
                    if (prot) begin
                        r_next.ctrl[4:0] = 5'h00;
                        r_next.op        = OP_IDLE;
                    end else begin
                        r_next.erase_go = r_reg.ctrl[4:0] == CMD_ERASE;
                        r_next.write_go = r_reg.ctrl[4:0] == CMD_WRITE;
                        r_next.pg_wr    = r_reg.ctrl[4:0] == CMD_WRITE;
                        r_next.page_sel = ptr_page;
                        r_next.op       = OP_BUSY;
                        r_next.win      = 3'h0;
                        // Busy raised for the concurrent section.
                        if (in_rww) begin
                            r_next.ctrl[`BIT_RWWB] = 1'h1;
                        end
                        r_next.halt = !in_rww;
                    end
                end
                // Fill both operands into the pointer word.
                default: begin
                    r_next.buf_load        = 1'h1;
                    r_next.buf_word        = flash_pointer[PW:1];
                    r_next.buf_data        = {operand_high_reg, operand_low_reg};
                    r_next.buf_full        = 1'h1;
                    // A fill clears the busy flag.
                    r_next.ctrl[`BIT_RWWB] = 1'h0;
                    r_next.ctrl[4:0]       = 5'h00;
                    r_next.op              = OP_IDLE;
                end
            endcase
        end else if (r_reg.op == OP_ARMED && r_reg.win == 3'h1) begin
            // Unused window drops the armed bits.
            r_next.ctrl[4:0] = 5'h00;
            r_next.op        = OP_IDLE;
        end

        // Store enable stays high until the array finishes.
        if (r_reg.op == OP_BUSY && flash_op_done) begin
            r_next.ctrl[4:0] = 5'h00;
            r_next.op        = OP_IDLE;
            r_next.halt      = 1'h0;
            if (r_reg.pg_wr) begin
                r_next.buf_full = 1'h0;
            end
        end

        // Software write of the control register.
        if (wr) begin
            r_next.ctrl[`BIT_IE] = pwdata[`BIT_IE];
            // Re-enable while loading discards the buffer.
            if (pwdata[`BIT_RWW_READ_REENABLE] && r_reg.buf_full) begin
                r_next.buf_discard = 1'h1;
                r_next.buf_full    = 1'h0;
            end
            // Only the five listed patterns are taken.
            wr_ok = (wcmd == CMD_FILL) || (wcmd == CMD_ERASE) ||
                    (wcmd == CMD_WRITE) || (wcmd == CMD_LOCK) ||
                    (wcmd == CMD_RWWEN);
            // Nothing is armed while an erase or write runs.
            if (wr_ok && r_reg.op != OP_BUSY) begin
                r_next.ctrl[4:0] = wcmd;
                r_next.op        = OP_ARMED;
                // Each accepted write reloads the window.
                r_next.win       = `WIN_CYC;
            end
        end

        // Lock or fuse read inside the load window.
        special = (r_reg.op == OP_ARMED) && (r_reg.ctrl[4:0] == CMD_LOCK)
                  && (r_reg.win >= `LPM_WIN_LAST);
        if (lpm_req) begin
            r_next.lpm_ack  = 1'h1;
            r_next.lpm_data = special ? (flash_pointer[0] ? fuse_low_in
                                         : {`LOCK_PAD, r_reg.locks}) : 8'h00;
            r_next.lpm_deny = !special && (
                (in_rww && r_reg.ctrl[`BIT_RWWB]) ||
                (HAS_BOOT && exec_in_boot && !in_boot && !r_reg.locks[`LK_APP_HI]) ||
                (HAS_BOOT && !exec_in_boot && in_boot && !r_reg.locks[`LK_BOOT_HI]));
        end

        // Only chip erase returns locks to unprogrammed.
        if (chip_erase) begin
            r_next.locks = `LOCK_RST;
        end

        r_next.ext_block    = !r_next.locks[`LK_MEM_LO];
        r_next.fuse_lock    = !r_next.locks[`LK_MEM_LO];
        r_next.verify_block = !r_next.locks[`LK_MEM_LO] && !r_next.locks[`LK_MEM_HI];
        r_next.bootlk_lock  = r_next.verify_block;
        // Vectors in the other section are switched off.
        r_next.vec_off = HAS_BOOT && (vectors_in_boot ?
                         (!exec_in_boot && !r_next.locks[`LK_APP_HI]) :
                         (exec_in_boot && !r_next.locks[`LK_BOOT_HI]));
        // Ready request follows enable, global flag and store enable.
        r_next.irq = r_next.ctrl[`BIT_IE] && global_irq_en && !r_next.ctrl[`BIT_SPMEN];
    end

    // Registered state; lock bits model unprogrammed cells after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg       <= '0;
            r_reg.op    <= OP_IDLE;
            r_reg.ctrl  <= `CTRL_RST;
            r_reg.locks <= `LOCK_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign prdata          = {24'h000000, r_reg.rdata};
    assign pready          = r_reg.ready;
    assign pslverr         = r_reg.slverr;
    assign cpu_halt        = r_reg.halt;
    assign ready_irq       = r_reg.irq;
    assign irq_vectors_off = r_reg.vec_off;
    assign lpm_ack         = r_reg.lpm_ack;
    assign lpm_data        = r_reg.lpm_data;
    assign lpm_deny        = r_reg.lpm_deny;
    assign buf_load        = r_reg.buf_load;
    assign buf_word        = r_reg.buf_word;
    assign buf_data        = r_reg.buf_data;
    assign buf_discard     = r_reg.buf_discard;
    assign page_erase_go   = r_reg.erase_go;
    assign page_write_go   = r_reg.write_go;
    assign page_sel        = r_reg.page_sel;
    assign rww_blocked     = r_reg.ctrl[`BIT_RWWB];
    assign ext_prog_block  = r_reg.ext_block;
    assign verify_block    = r_reg.verify_block;
    assign fuse_lock       = r_reg.fuse_lock;
    assign boot_lock_lock  = r_reg.bootlk_lock;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Helper for the lock store check.
    logic spm_go_lock;
    assign spm_go_lock = spm_req && (r_reg.op == OP_ARMED) && (r_reg.win != 3'h0)
                         && (r_reg.ctrl[4:0] == CMD_LOCK) && (HAS_BOOT || !selfprog_fuse_n);

    sequence accepted_write_s;
        wr && (r_reg.op != OP_BUSY) && (pwdata[4:0] == CMD_FILL);
    endsequence

    sequence unused_window_s;
        (r_reg.op == OP_ARMED) && !spm_req ##1 (!spm_req && !wr) [*3];
    endsequence

    win_load_a: assert property (accepted_write_s |=> r_reg.win == `WIN_CYC)
        else $error("window not loaded");
    win_expire_a: assert property ((r_reg.win == `WIN_CYC) ##0 unused_window_s
                                   |=> !r_reg.ctrl[`BIT_SPMEN])
        else $error("store enable outlived window");
    busy_hold_a: assert property ((r_reg.op == OP_BUSY) && !flash_op_done && !wr
                                  |=> r_reg.ctrl[`BIT_SPMEN])
        else $error("store enable fell during operation");
    bad_pattern_a: assert property (wr && (pwdata[4:0] == 5'h07) && !spm_req
                                    && (r_reg.win != 3'h1)
                                    |=> $stable(r_reg.ctrl[4:0]))
        else $error("invalid pattern took effect");
    res_bit_a: assert property (pready |-> !prdata[`BIT_RES])
        else $error("reserved bit read as one");
    irq_level_a: assert property (r_reg.ctrl[`BIT_IE] && global_irq_en
                                  && !r_reg.ctrl[`BIT_SPMEN] ##1 r_reg.ctrl[`BIT_IE]
                                  && !r_reg.ctrl[`BIT_SPMEN] && $stable(global_irq_en)
                                  |-> ready_irq)
        else $error("ready request missing");
    rww_set_a: assert property (page_erase_go && !cpu_halt |-> rww_blocked)
        else $error("busy not set for concurrent section");
    halt_span_a: assert property (cpu_halt && !flash_op_done |=> cpu_halt)
        else $error("halt released early");
    lock_prog_a: assert property (spm_go_lock && !chip_erase
                                  |=> r_reg.locks == $past(r_reg.locks & operand_low_reg[5:0]))
        else $error("lock bits wrong after lock store");
    fill_clr_a: assert property (buf_load |-> !rww_blocked)
        else $error("busy survived buffer fill");

endmodule : self_program_flash_control

//--- core_model.sv
// Processor core and flash array model facing the self-program controller.
`timescale 1ns/1ps
module core_model (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Array start pulses.
    input  wire logic        page_erase_go,
    input  wire logic        page_write_go,
    // Core and array signals.
    output logic             spm_req,
    output logic             lpm_req,
    output logic [15:0]      flash_pointer,
    output logic [7:0]       operand_low_reg,
    output logic [7:0]       operand_high_reg,
    output logic             flash_op_done
);
    int lat = 3;
    int cnt = 0;
    // ======================================================================
    // Array timing
    // ======================================================================
    // A slow array is only a larger lat, so one model covers both paces.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            flash_op_done <= 1'b0;
        end else begin
            flash_op_done <= (cnt == 1);
            if (page_erase_go || page_write_go) begin
                cnt <= lat;
            end else if (cnt > 0) begin
                cnt <= cnt - 1;
            end
        end
    end
    // Idle core values at time zero.
    initial begin
        spm_req = 1'b0;
        lpm_req = 1'b0;
        flash_pointer = 16'h0;
        operand_low_reg = 8'h0;
        operand_high_reg = 8'h0;
    end
    // One instruction; released operands show their inverse so stale data never matches.
    task automatic instr(input bit ld, input logic [15:0] z, input logic [7:0] l,
                         input logic [7:0] h);
        @(posedge pclk);
        spm_req <= !ld;
        lpm_req <= ld;
        flash_pointer <= ld ? z : {z[15:1], 1'b0};
        operand_low_reg <= l;
        operand_high_reg <= h;
        @(posedge pclk);
        spm_req <= 1'b0;
        lpm_req <= 1'b0;
        flash_pointer <= ~flash_pointer;
        operand_low_reg <= ~l;
        operand_high_reg <= ~h;
    endtask : instr
endmodule : core_model

//--- self_program_flash_control_tb.sv
// Self-checking bench of the self-program flash controller.
`timescale 1ns/1ps
`include "selfprog_defs.svh"
module self_program_flash_control_tb;
    import selfprog_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, cer = 0;
    logic [11:0] paddr = 0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, spm, load_program_instr, done, halt, irq, ack, bload, disc, dny, l_deny;
    logic        ego, wgo, rwwb, eb, vb, fl, bl;
    logic [15:0] fp, bdata, l_data;
    logic [7:0]  lo, hi, ldata, l_lpm, o;
    logic [4:0]  bword, l_word, w;
    logic [6:0]  psl, l_page;
    int          err_count = 0, n_tests = 0, n_load = 0, n_disc = 0, n_go = 0, t;
    always #12.5 pclk = ~pclk;
    self_program_flash_control dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .spm_req(spm), .lpm_req(load_program_instr),
        .flash_pointer(fp), .operand_low_reg(lo), .operand_high_reg(hi),
        .global_irq_en(gie), .exec_in_boot(1'b0), .vectors_in_boot(1'b0), .cpu_halt(halt),
        .ready_irq(irq), .irq_vectors_off(), .lpm_ack(ack), .lpm_data(ldata), .lpm_deny(dny),
        .selfprog_fuse_n(1'b0), .fuse_low_in(8'h62), .chip_erase(cer),
        .flash_op_done(done), .buf_load(bload), .buf_word(bword), .buf_data(bdata),
        .buf_discard(disc), .page_erase_go(ego), .page_write_go(wgo), .page_sel(psl),
        .rww_blocked(rwwb), .ext_prog_block(eb), .verify_block(vb), .fuse_lock(fl),
        .boot_lock_lock(bl));
    core_model core (.pclk(pclk), .presetn(presetn), .page_erase_go(ego),
        .page_write_go(wgo), .spm_req(spm), .lpm_req(load_program_instr), .flash_pointer(fp),
        .operand_low_reg(lo), .operand_high_reg(hi), .flash_op_done(done));
    // ======================================================================
    // Monitors and helpers
    // ======================================================================
    // Sticky records of one-cycle outputs, sampled before the edge updates land.
    always @(posedge pclk) begin
        if (bload === 1'b1) begin
            n_load <= n_load + 1;
            l_word <= bword;
            l_data <= bdata;
        end
        if (disc === 1'b1) n_disc <= n_disc + 1;
        if (ego === 1'b1 || wgo === 1'b1) begin
            n_go <= n_go + 1;
            l_page <= psl;
        end
        if (ack === 1'b1) begin
            l_lpm <= ldata;
            l_deny <= dny;
        end
    end
    // Only the five accepted low patterns change the command bits.
    function automatic logic [7:0] model(input logic [7:0] m, input logic [7:0] d);
        model = {d[7], m[6:5], (d[4:0] inside {5'h01, 5'h03, 5'h05, 5'h09, 5'h11}) ?
                 d[4:0] : m[4:0]};
    endfunction : model
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // APB transfer; holds the request until pready is seen high at a rising edge.
    task automatic apb(input bit wr, input logic [11:0] a, input logic [7:0] d,
                       input logic [3:0] s = 4'hf);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait on a slave that never answers.
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [7:0] e);
        apb(0, `CTRL_ADDR, 8'h0);
        chk(rd, {24'h0, e});
    endtask : rdc
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : idle
    task automatic conclude;
        if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    // ======================================================================
    // Tests
    // ======================================================================
    initial begin
        #(25ns * 4000);
        err_count++;
        conclude();
    end
    initial begin
        void'($urandom(41));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CTRL_RST); // reset value
        apb(0, 12'h0d8, 8'h0);
        chk(err, 1'b1);
        apb(1, `CTRL_ADDR, 8'h27);
        rdc(model(8'h00, 8'h27)); // invalid pattern, reserved bit
        apb(1, `CTRL_ADDR, 8'h01, 4'h0);
        rdc(8'h00);
        apb(1, `CTRL_ADDR, 8'h01);
        idle(5);
        rdc(8'h00); // unused window expires
        w = 5'($urandom);
        o = 8'($urandom);
        apb(1, `CTRL_ADDR, 8'h01);
        core.instr(0, {3'h0, 7'h05, w, 1'b1}, o, ~o);
        idle(2);
        chk({l_word, l_data, 8'(n_load)}, {w, ~o, o, 8'h01}); // fill word
        rdc(8'h00); // cleared after store
        apb(1, `CTRL_ADDR, 8'h11);
        core.instr(0, 16'h0, 8'h0, 8'h0);
        idle(2);
        chk(n_disc, 1); // loaded data discarded
        core.lat = 20;
        apb(1, `CTRL_ADDR, 8'h03);
        core.instr(0, {3'h0, 7'h02, 6'h0}, 8'h0, 8'h0);
        idle(2);
        chk({rwwb, l_page}, {1'b1, 7'h02}); // erase sets busy
        apb(1, `CTRL_ADDR, 8'h11);
        rdc(8'h43); // refused while busy
        core.instr(1, 16'h0000, 8'h0, 8'h0);
        idle(2);
        chk(l_deny, 1'b1); // busy section read refused
        for (t = 0; t < 40 && done !== 1'b1; t++) idle(1);
        chk(done, 1'b1); // erase completes in time
        idle(2);
        rdc(8'h40);
        apb(1, `CTRL_ADDR, 8'h11);
        core.instr(0, 16'h0, 8'h0, 8'h0);
        idle(2);
        chk(rwwb, 1'b0); // re-enable clears busy
        core.lat = 3;
        apb(1, `CTRL_ADDR, 8'h05);
        // word index zero for page write
        core.instr(0, {3'h0, 7'h64, 6'h0}, 8'h0, 8'h0);
        idle(1);
        chk({halt, l_page}, {1'b1, 7'h64}); // halted on no_concurrent_read_section write
        idle(6);
        chk({halt, rwwb}, 2'b00); // released after done
        // application store lock set along with the memory low lock
        apb(1, `CTRL_ADDR, 8'h09);
        core.instr(0, 16'hffff, 8'hfa, 8'h00);
        idle(2);
        chk({eb, vb, fl, bl}, 4'b1010); // mode two
        apb(1, `CTRL_ADDR, 8'h09);
        core.instr(1, 16'h0000, 8'h0, 8'h0);
        idle(2);
        chk({l_deny, l_lpm}, {1'b0, 8'hfa}); // lock byte read
        t = n_go;
        apb(1, `CTRL_ADDR, 8'h03);
        core.instr(0, 16'h0, 8'h0, 8'h0);
        idle(3);
        chk(n_go, t); // application store blocked
        @(posedge pclk);
        cer <= 1'b1;
        @(posedge pclk);
        cer <= 1'b0;
        idle(2);
        chk(eb, 1'b0); // chip erase unlocks
        @(posedge pclk);
        gie <= 1'b1;
        apb(1, `CTRL_ADDR, 8'h80);
        idle(2);
        chk(irq, 1'b1); // ready request
        apb(1, `CTRL_ADDR, 8'h81);
        idle(1);
        chk(irq, 1'b0); // held off while armed
        conclude();
    end
endmodule : self_program_flash_control_tb
